// ==== common/sram_burst_pkg.sv ====
// Constants and carrier types of the burst SRAM cycle interface
`default_nettype none
package sram_burst_pkg;
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int CNT_W = 2;
  localparam int BUF_DEPTH = 2;
  localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
  localparam logic [LANES-1:0] STROBE_NONE = 4'hF;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } burst_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] strobe_n;
  } wr_entry_t;
endpackage
`default_nettype wire

// ==== hdl/sram_burst_cycle.sv ====
// Synchronous flow-through burst SRAM core with write buffer
`timescale 1ns/100ps
`default_nettype none
module sram_burst_cycle (
  input wire logic clock,
  input wire logic srst,
  input wire logic [sram_burst_pkg::ADDR_W-1:0] addr,
  input wire logic read_not_write,
  input wire logic burst_step_or_load,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic clk_enable_n,
  input wire logic [sram_burst_pkg::LANES-1:0] byte_write_strobe_n,
  input wire logic linear_burst_order,
  input wire logic output_enable_n,
  input wire logic [sram_burst_pkg::DATA_W-1:0] write_word,
  output logic [sram_burst_pkg::DATA_W-1:0] read_word,
  output logic data_oe_n
);
  localparam int AW = sram_burst_pkg::ADDR_W;
  localparam int DW = sram_burst_pkg::DATA_W;
  localparam int LW = sram_burst_pkg::LANE_W;
  localparam int NL = sram_burst_pkg::LANES;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  sram_burst_pkg::burst_state_t state_q;
  logic [AW-1:0] base_q;
  logic [sram_burst_pkg::CNT_W-1:0] cnt_q;
  logic interleave_q;
  logic pend_rd_q;
  logic pend_wr_q;
  logic [AW-1:0] pend_addr_q;
  logic [NL-1:0] pend_strobe_q;
  logic [DW-1:0] read_q;
  logic drive_q;
  sram_burst_pkg::wr_entry_t ent_q [0:sram_burst_pkg::BUF_DEPTH-1];
  logic head_q;
  logic [1:0] fill_q;

  logic en, sel, load, step, rd_load, wr_load, do_step, deselect;
  logic [sram_burst_pkg::CNT_W-1:0] cnt_d;
  logic [AW-1:0] step_addr;
  logic push_valid, push_ready, pop_valid, pop_ready, full;
  logic [DW-1:0] fwd_word;
  sram_burst_pkg::wr_entry_t push_ent, pop_ent;

  // Burst address from base and count; order fixed at load
  function automatic logic [AW-1:0] burst_addr(
    input logic [AW-1:0] base,
    input logic [sram_burst_pkg::CNT_W-1:0] cnt,
    input logic ilv);
    logic [1:0] low;
    low = ilv ? (base[1:0] ^ cnt) : 2'(base[1:0] + cnt);
    return {base[AW-1:2], low};
  endfunction

  // Byte-lane merge of a buffered write over a word
  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] word,
    input sram_burst_pkg::wr_entry_t ent,
    input logic hit);
    logic [DW-1:0] res;
    res = word;
    for (int i = 0; i < NL; i++) begin
      if (hit && !ent.strobe_n[i]) begin
        res[i*LW +: LW] = ent.data[i*LW +: LW];
      end
    end
    return res;
  endfunction

  always_comb begin
    en = !clk_enable_n;
    sel = !chip_select_a_n && !chip_select_c_n && chip_select_b;
    load = !burst_step_or_load;
    step = burst_step_or_load;
    rd_load = en && load && sel && read_not_write;
    wr_load = en && load && sel && !read_not_write;
    deselect = en && load && !sel;
    do_step = en && step && (state_q != sram_burst_pkg::ST_IDLE);
    cnt_d = sram_burst_pkg::CNT_W'(cnt_q + 2'h1);
    step_addr = burst_addr(base_q, cnt_d, interleave_q);
  end

  // Burst state and counter; a disabled edge changes nothing
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= sram_burst_pkg::ST_IDLE;
      base_q <= '0;
      cnt_q <= sram_burst_pkg::CNT_RESET;
      interleave_q <= 1'b0;
    end else if (en) begin
      if (load) begin
        cnt_q <= sram_burst_pkg::CNT_RESET;
        base_q <= addr;
        interleave_q <= linear_burst_order;
        case (state_q)
          sram_burst_pkg::ST_IDLE,
          sram_burst_pkg::ST_READ,
          sram_burst_pkg::ST_WRITE: begin
            if (!sel) begin
              state_q <= sram_burst_pkg::ST_IDLE;
            end else if (read_not_write) begin
              state_q <= sram_burst_pkg::ST_READ;
            end else begin
              state_q <= sram_burst_pkg::ST_WRITE;
            end
          end
          default: state_q <= sram_burst_pkg::ST_IDLE;
        endcase
      end else if (do_step) begin
        cnt_q <= cnt_d;
      end
    end
  end

  // Access of this edge becomes the transfer of the next enabled edge
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_rd_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_addr_q <= '0;
      pend_strobe_q <= sram_burst_pkg::STROBE_NONE;
    end else if (en) begin
      pend_rd_q <= rd_load || (do_step && state_q == sram_burst_pkg::ST_READ);
      pend_wr_q <= wr_load || (do_step && state_q == sram_burst_pkg::ST_WRITE);
      pend_addr_q <= load ? addr : step_addr;
      pend_strobe_q <= byte_write_strobe_n;
    end
  end

  // Read merges any buffered write not yet in the array
  always_comb begin
    logic hit0, hit1;
    sram_burst_pkg::wr_entry_t old_e, new_e;
    old_e = ent_q[head_q];
    new_e = ent_q[!head_q];
    hit0 = (fill_q != 2'h0) && (old_e.addr == pend_addr_q);
    hit1 = (fill_q == 2'h2) && (new_e.addr == pend_addr_q);
    fwd_word = lane_merge(lane_merge(mem[pend_addr_q], old_e, hit0),
                          new_e, hit1);
  end

  // Flow-through data slot; held on stalls, dropped after deselect
  always_ff @(posedge clock) begin
    if (srst) begin
      read_q <= sram_burst_pkg::DATA_RESET;
      drive_q <= 1'b0;
    end else if (en) begin
      drive_q <= pend_rd_q;
      if (pend_rd_q) begin
        read_q <= fwd_word;
      end
    end
  end

  // Pins drive only in a read data slot; enable pin acts at once
  assign read_word = read_q;
  assign data_oe_n = !(drive_q && !output_enable_n);

  // Two-entry write buffer; array port is shared with read transfers
  always_comb begin
    full = (fill_q == 2'h2);
    push_valid = en && pend_wr_q;
    push_ent.addr = pend_addr_q;
    push_ent.data = write_word;
    push_ent.strobe_n = pend_strobe_q;
    pop_valid = (fill_q != 2'h0);
    pop_ent = ent_q[head_q];
    // Reads win the port unless the buffer is full
    pop_ready = en && (!pend_rd_q || full);
    push_ready = !full || (pop_valid && pop_ready);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      head_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      if (pop_valid && pop_ready) begin
        head_q <= !head_q;
      end
      case ({push_valid && push_ready, pop_valid && pop_ready})
        2'b10: fill_q <= 2'(fill_q + 2'h1);
        2'b01: fill_q <= 2'(fill_q - 2'h1);
        default: fill_q <= fill_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (push_valid && push_ready) begin
      ent_q[1'(head_q + fill_q[0])] <= push_ent;
    end
  end

  // Array write, lane by lane
  always_ff @(posedge clock) begin
    if (pop_valid && pop_ready) begin
      for (int i = 0; i < NL; i++) begin
        if (!pop_ent.strobe_n[i]) begin
          mem[pop_ent.addr][i*LW +: LW] <= pop_ent.data[i*LW +: LW];
        end
      end
    end
  end

  // Checks
  property p_read_load;
    @(posedge clock) disable iff (srst)
    rd_load ##1 en |=> drive_q;
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read not driven");

  property p_burst_read;
    @(posedge clock) disable iff (srst)
    (do_step && state_q == sram_burst_pkg::ST_READ) ##1 en |=> drive_q;
  endproperty
  a_burst_read: assert property (p_burst_read)
    else $error("burst word missing");

  property p_wrap;
    @(posedge clock) disable iff (srst)
    do_step && !load |=> cnt_q == 2'($past(cnt_q) + 2'h1);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter step wrong");

  property p_stall_hold;
    @(posedge clock) disable iff (srst)
    !en && drive_q |=> drive_q && $stable(read_q);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("stalled word moved");

  property p_frozen;
    @(posedge clock) disable iff (srst)
    !en |=> $stable(state_q) && $stable(cnt_q) && $stable(pend_rd_q)
      && $stable(pend_wr_q) && $stable(base_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved on stall");

  property p_stall_read;
    @(posedge clock) disable iff (srst)
    rd_load ##1 !en |=> pend_rd_q;
  endproperty
  a_stall_read: assert property (p_stall_read)
    else $error("stalled read lost");

  property p_deselect;
    @(posedge clock) disable iff (srst)
    deselect ##1 en |=> !drive_q;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("bus not released");

  property p_pending;
    @(posedge clock) disable iff (srst)
    deselect && pend_rd_q |=> drive_q;
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending read dropped");

  property p_reset_z;
    @(posedge clock) srst |=> data_oe_n;
  endproperty
  a_reset_z: assert property (p_reset_z)
    else $error("bus driven after reset");

  property p_dir_fixed;
    @(posedge clock) disable iff (srst)
    do_step |=> state_q == $past(state_q);
  endproperty
  a_dir_fixed: assert property (p_dir_fixed)
    else $error("step changed direction");

  property p_write_taken;
    @(posedge clock) disable iff (srst)
    push_valid |-> push_ready;
  endproperty
  a_write_taken: assert property (p_write_taken)
    else $error("write word lost");

  c_burst4: cover property (@(posedge clock) disable iff (srst)
    rd_load ##1 do_step [*3]);
  c_write_burst: cover property (@(posedge clock) disable iff (srst)
    wr_load ##1 do_step [*3]);
  c_stall: cover property (@(posedge clock) disable iff (srst)
    drive_q && !en ##1 !en);
  c_full: cover property (@(posedge clock) disable iff (srst) full);
endmodule
`default_nettype wire

// ==== tb/sram_ctrl_model.sv ====
// Memory controller model that drives the SRAM pins
`timescale 1ns/100ps
`default_nettype none
module sram_ctrl_model (
  input wire logic clock,
  output logic [16:0] addr,
  output logic read_not_write,
  output logic burst_step_or_load,
  output logic chip_select_a_n,
  output logic chip_select_b,
  output logic chip_select_c_n,
  output logic clk_enable_n,
  output logic [3:0] byte_write_strobe_n,
  output logic [35:0] write_word
);
  // Selects dropped on deselect: bit0 a, bit1 c, bit2 b
  logic [2:0] pick = 3'h7;
  initial begin
    {addr, read_not_write, burst_step_or_load} = '0;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
    clk_enable_n = 1'b0;
    byte_write_strobe_n = 4'hF;
    write_word = 36'h0;
  end
  // Op 0 read load, 1 write load, 2 step, 3 deselect, 4 stalled edge
  task automatic beat(input int op, input logic [16:0] a,
      input logic [35:0] d, input logic dv, input logic [3:0] bw);
    logic off;
    off = (op == 3);
    @(posedge clock);
    clk_enable_n <= (op == 4);
    burst_step_or_load <= (op == 4) ? ~burst_step_or_load : (op == 2);
    // Flipped on steps so a core that obeys it goes wrong
    read_not_write <= (op < 2) ? (op == 0) : ~read_not_write;
    addr <= (op < 2) ? a : ~addr;
    chip_select_a_n <= off && pick[0];
    chip_select_c_n <= off && pick[1];
    chip_select_b <= !(off && pick[2]);
    byte_write_strobe_n <= bw;
    write_word <= dv ? d : ~write_word;
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the burst SRAM cycle core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef int row_t [10];
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic output_enable_n = 1'b0;
  logic linear_burst_order = 1'b0;
  logic [16:0] addr;
  logic rnw, step, cs_a_n, cs_b, cs_c_n, cen_n, oe_n;
  logic [3:0] bw_n;
  logic [35:0] wdata, rdata;
  int err_total = 0;
  int n_checks = 0;

  always #4 clock = ~clock;

  sram_ctrl_model ctrl_u (.clock(clock), .addr(addr),
    .read_not_write(rnw), .burst_step_or_load(step),
    .chip_select_a_n(cs_a_n), .chip_select_b(cs_b),
    .chip_select_c_n(cs_c_n), .clk_enable_n(cen_n),
    .byte_write_strobe_n(bw_n), .write_word(wdata));
  sram_burst_cycle dut_u (.clock(clock), .srst(srst), .addr(addr),
    .read_not_write(rnw), .burst_step_or_load(step),
    .chip_select_a_n(cs_a_n), .chip_select_b(cs_b),
    .chip_select_c_n(cs_c_n), .clk_enable_n(cen_n),
    .byte_write_strobe_n(bw_n), .linear_burst_order(linear_burst_order),
    .output_enable_n(output_enable_n), .write_word(wdata),
    .read_word(rdata), .data_oe_n(oe_n));

  function automatic logic [35:0] pat(input int a);
    logic [8:0] v;
    v = a[8:0];
    return {v, ~v, v ^ 9'h1A5, v + 9'h033};
  endfunction

  task automatic chk_word(input logic [35:0] exp);
    n_checks++;
    if ({oe_n, rdata} !== {1'b0, exp}) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time,
        {oe_n, rdata}, {1'b0, exp});
    end
  endtask

  task automatic chk_z();
    n_checks++;
    if (oe_n !== 1'b1) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, oe_n, 1'b1);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Expect -1 bus released, -2 not looked at
  task automatic run(input row_t op, input row_t ad, input row_t wd,
      input row_t ex);
    for (int k = 0; k < 10; k++) begin
      ctrl_u.beat(op[k], ad[k][16:0], pat(wd[k]), wd[k] >= 0, 4'h0);
      if (ex[k] == -1) chk_z();
      else if (ex[k] >= 0) chk_word(pat(ex[k]));
    end
  endtask

  task automatic t_stream();
    for (int i = 0; i < 5; i++)
      ctrl_u.beat(i < 4 ? 1 : 3, 17'(8 + i), pat(7 + i), i > 0, 4'h0);
    for (int i = 0; i < 6; i++) begin
      ctrl_u.beat(i < 4 ? 0 : 3, 17'(8 + i), 36'h0, 1'b0, 4'hF);
      if (i > 1) chk_word(pat(6 + i));
    end
    ctrl_u.beat(3, 17'h0, 36'h0, 1'b0, 4'hF);
    chk_z();
    $display("t_stream done");
  endtask

  task automatic t_burst(input logic ilv, input int s0, s1, s2, s3);
    @(posedge clock);
    linear_burst_order <= ilv;
    ctrl_u.pick = ilv ? 3'h2 : 3'h4;
    run('{1, 2, 2, 2, 3, 3, 3, 3, 3, 3}, '{0: s0, default: 0},
      '{-1, s0, s1, s2, s3, -1, -1, -1, -1, -1}, '{10{-2}});
    run('{0, 2, 2, 2, 2, 3, 3, 3, 3, 3}, '{0: s0, default: 0}, '{10{-1}},
      '{-2, -2, s0, s1, s2, s3, s0, -1, -2, -2});
    $display("t_burst done");
  endtask

  task automatic t_stall();
    ctrl_u.pick = 3'h1;
    run('{0, 4, 0, 4, 4, 0, 3, 3, 3, 3}, '{8, 0, 9, 0, 0, 10, 0, 0, 0, 0},
      '{10{-1}},
      '{-1, -1, -1, 8, 8, 8, 9, 10, -1, -2});
    run('{1, 4, 1, 4, 4, 3, 0, 0, 3, 3}, '{64, 0, 65, 0, 0, 0, 64, 65, 0, 0},
      '{-1, -1, 64, -1, -1, 65, -1, -1, -1, -1},
      '{-2, -2, -2, -2, -2, -2, -2, -2, 64, 65});
    $display("t_stall done");
  endtask

  task automatic t_oe();
    ctrl_u.beat(0, 17'h8, 36'h0, 1'b0, 4'hF);
    ctrl_u.beat(3, 17'h0, 36'h0, 1'b0, 4'hF);
    ctrl_u.beat(4, 17'h0, 36'h0, 1'b0, 4'hF);
    @(posedge clock);
    output_enable_n <= 1'b1;
    @(negedge clock);
    chk_z();
    @(posedge clock);
    output_enable_n <= 1'b0;
    @(negedge clock);
    chk_word(pat(8));
    ctrl_u.beat(3, 17'h0, 36'h0, 1'b0, 4'hF);
    $display("t_oe done");
  endtask

  task automatic t_lanes();
    logic [3:0] bw;
    logic [35:0] nw, m;
    for (int j = 0; j < 2; j++) begin
      bw = j ? 4'h5 : 4'hA;
      nw = ~pat(8 + j);
      m = {{9{~bw[3]}}, {9{~bw[2]}}, {9{~bw[1]}}, {9{~bw[0]}}};
      ctrl_u.beat(1, 17'(8 + j), 36'h0, 1'b0, bw);
      ctrl_u.beat(3, 17'h0, nw, 1'b1, 4'hF);
      ctrl_u.beat(0, 17'(8 + j), 36'h0, 1'b0, 4'hF);
      ctrl_u.beat(3, 17'h0, 36'h0, 1'b0, 4'hF);
      ctrl_u.beat(3, 17'h0, 36'h0, 1'b0, 4'hF);
      chk_word((nw & m) | (pat(8 + j) & ~m));
    end
    $display("t_lanes done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    chk_z();
    $display("t_reset done");
    t_stream();
    t_burst(1'b0, 33, 34, 35, 32);
    t_burst(1'b1, 49, 48, 51, 50);
    t_stall();
    t_oe();
    t_lanes();
    summarize();
  end

  // About 110 cycles of traffic; over twenty-five times that means a hang
  initial begin
    #24000;
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
